// >>> rtl/ira_cfg.svh
// Constants of the interrupt request aggregator: sizes, source numbers, codes and reset values.
`ifndef IRA_CFG_SVH
`define IRA_CFG_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define IRA_NUM_SRC 24
`define IRA_SRC_ID_W 5
`define IRA_PRIO_W 2
`define IRA_NUM_EXT 4
`define IRA_NUM_UART 4
`define IRA_NUM_TMR3 3
`define IRA_NUM_ARR_EVT 8
`define IRA_NUM_TWOWIRE 2
`define IRA_NUM_COMP 3
`define IRA_FLAG_W 55

// ----------------------------------------------------------------------------
// Source numbers, which are also the vector identifiers
// ----------------------------------------------------------------------------
`define IRA_SRC_EXT0 5'h00
`define IRA_SRC_TMR0 5'h01
`define IRA_SRC_EXT1 5'h02
`define IRA_SRC_TMR1 5'h03
`define IRA_SRC_UART0 5'h04
`define IRA_SRC_TMR2 5'h05
`define IRA_SRC_EXT2 5'h06
`define IRA_SRC_SPI 5'h07
`define IRA_SRC_ADC 5'h08
`define IRA_SRC_ARRAY 5'h09
`define IRA_SRC_SYSTEM 5'h0A
`define IRA_SRC_KEYPAD 5'h0B
`define IRA_SRC_TWOWIRE0 5'h0C
`define IRA_SRC_COMP0 5'h0D
`define IRA_SRC_UART1 5'h0E
`define IRA_SRC_EXT3 5'h0F
`define IRA_SRC_TMR3 5'h10
`define IRA_SRC_COMP1 5'h11
`define IRA_SRC_DMA 5'h12
`define IRA_SRC_COMP2 5'h13
`define IRA_SRC_UART2 5'h14
`define IRA_SRC_TMR4 5'h15
`define IRA_SRC_UART3 5'h16
`define IRA_SRC_TWOWIRE1 5'h17

// ----------------------------------------------------------------------------
// Comparator edge selection codes
// ----------------------------------------------------------------------------
`define IRA_EDGE_NONE 2'h0
`define IRA_EDGE_RISE 2'h1
`define IRA_EDGE_FALL 2'h2
`define IRA_EDGE_BOTH 2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IRA_FLAGS_RST 55'h00_0000_0000_0000
`define IRA_REQ_RST 24'h00_0000
`define IRA_PRIO_RST 48'h0000_0000_0000

`endif

// >>> rtl/ira_pkg.sv
// Types shared by the interrupt request aggregator modules.
`include "ira_cfg.svh"

package ira_pkg;

  // --------------------------------------------------------------------------
  // Flag groups
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic tx;
    logic rx;
  } ira_uart_t;

  typedef struct packed {
    logic low;
    logic ext;
    logic ovf;
  } ira_tmr3_t;

  typedef struct packed {
    logic smp;
    logic win;
    logic done;
  } ira_adc_t;

  typedef struct packed {
    logic stop_det;
    logic start_det;
    logic brk1;
    logic brk0;
    logic missing_clk;
    logic stack_warn;
    logic wdt;
    logic bo1;
    logic bo0;
    logic rtc;
  } ira_sys_t;

  typedef struct packed {
    logic tmr_b;
    logic tmr_a;
    logic done;
  } ira_dma_t;

  // All request flags held by the aggregator.
  typedef struct packed {
    logic [`IRA_NUM_EXT-1:0] ext;
    logic [1:0] tmr01;
    ira_uart_t [`IRA_NUM_UART-1:0] uart;
    ira_tmr3_t [`IRA_NUM_TMR3-1:0] tmr234;
    logic spi;
    ira_adc_t adc;
    logic arr_ovf;
    logic [`IRA_NUM_ARR_EVT-1:0] arr_evt;
    ira_sys_t sys;
    logic keypad;
    logic [`IRA_NUM_TWOWIRE-1:0] twowire;
    logic [`IRA_NUM_COMP-1:0] comp;
    ira_dma_t dma;
  } ira_flags_t;

  // --------------------------------------------------------------------------
  // Comparator edge selection
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IRA_EDGE_NONE = `IRA_EDGE_NONE,
    IRA_EDGE_RISE = `IRA_EDGE_RISE,
    IRA_EDGE_BOTH = `IRA_EDGE_BOTH,
    IRA_EDGE_FALL = `IRA_EDGE_FALL
  } ira_edge_t;

  typedef logic [`IRA_PRIO_W-1:0] ira_prio_t;

endpackage

// >>> rtl/ira_ext_flag.sv
// Request flag of one external interrupt pin, level or transition activated.
`timescale 1ns/100ps
`default_nettype none

module ira_ext_flag
  import ira_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Pin and configuration
  input wire logic pin,
  input wire logic type_select,
  input wire logic polarity_invert,
  // Flag control
  input wire logic vec_clr,
  input wire logic sw_set,
  input wire logic sw_clr,
  // Flag state
  output logic flag_nxt,
  output logic flag
);

  logic active;
  logic active_q_r;
  logic edge_seen;
  logic edge_keep;

  // The pin is active low unless the polarity is inverted.
  assign active = polarity_invert ? pin : ~pin;
  assign edge_seen = active & ~active_q_r;
  assign edge_keep = flag & ~sw_clr & ~vec_clr;

  // In level mode the source controls the flag; a new edge wins over any clear.
  assign flag_nxt = type_select ? (edge_keep | edge_seen | sw_set) : (active | sw_set);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      active_q_r <= 1'b0;
      flag <= 1'b0;
    end
    else if (ce)
    begin
      active_q_r <= active;
      flag <= flag_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/ira_top.sv
// Interrupt request aggregator: request flags, per-source requests, priorities.
//
// Overview of operation
// - Each external input is level or transition activated by its type bit.
// - Each external input sets its own request flag.
// - Vectoring clears external flag only in transition mode; level mode follows source.
// - DMA request is channel done OR either DMA timer flag; no auto clear.
// - Timer 0/1 flags set on rollover, cleared when their vector is taken.
// - Serial port 0 request is receive OR transmit; software clears both.
// - Serial ports 1 to 3 combine receive and transmit like port 0.
// - Timer 2 request ORs overflow, external, and low byte in split mode.
// - Timers 3 and 4 requests are built exactly like timer 2.
// - SPI flag set on transfer done, kept through vectoring.
// - ADC request from done, window and sample flags; no auto clear.
// - Counter array request ORs base overflow and eight module event flags.
// - System request ORs the ten system flags; none cleared on vectoring.
// - Routing enable adds serial port 0 transmit flag to system request.
// - Keypad flag set on pattern match, not cleared on vectoring.
// - Each two-wire port flag set on new bus state, kept on vectoring.
// - Comparator flags set on selected output edge, kept on vectoring.
// - Software set and clear act on every flag exactly like hardware.
// - Type bit 0 is low level, 1 falling edge; invert gives high/rising.
// - A request passes only with global enable and its own enable set.
// - Each source carries a two-bit priority; 11 highest, 00 lowest.
`timescale 1ns/100ps
`default_nettype none

`include "ira_cfg.svh"

module ira_top
  import ira_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // External interrupt pins and their configuration
  input wire logic [`IRA_NUM_EXT-1:0] EXT_IRQ_PIN,
  input wire logic [`IRA_NUM_EXT-1:0] EXT_TYPE_SELECT,
  input wire logic [`IRA_NUM_EXT-1:0] EXT_POLARITY_INVERT,
  // Peripheral event pulses, one per flag
  input wire ira_flags_t HW_SET,
  // Software flag writes, one-cycle pulses
  input wire ira_flags_t SW_SET,
  input wire ira_flags_t SW_CLR,
  // Source modifiers
  input wire logic [`IRA_NUM_TMR3-1:0] SPLIT_MODE,
  input wire logic UART0_TX_TO_SYSTEM_ROUTE_ENABLE,
  input wire logic [`IRA_NUM_COMP-1:0] COMP_OUT,
  input wire ira_edge_t [`IRA_NUM_COMP-1:0] COMP_EDGE_SEL,
  // Enables and priorities
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [`IRA_NUM_SRC-1:0] SRC_ENABLE,
  input wire logic [`IRA_NUM_SRC-1:0] PRIO_HIGH,
  input wire logic [`IRA_NUM_SRC-1:0] PRIO_LOW,
  // Vector taken by the core
  input wire logic VEC_TAKE,
  input wire logic [`IRA_SRC_ID_W-1:0] VEC_ID,
  // Flag state and requests
  output ira_flags_t FLAGS,
  output logic [`IRA_NUM_SRC-1:0] IRQ_REQ,
  output ira_prio_t [`IRA_NUM_SRC-1:0] IRQ_PRIO,
  output logic IRQ_PEND
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Next value of a block of flags; any set wins over any clear.
  function automatic logic [`IRA_FLAG_W-1:0] flag_upd(
    input logic [`IRA_FLAG_W-1:0] cur,
    input logic [`IRA_FLAG_W-1:0] set,
    input logic [`IRA_FLAG_W-1:0] clr
  );
    flag_upd = (cur & ~clr) | set;
  endfunction

  // Combined request of a three-flag timer.
  function automatic logic tmr3_req(
    input ira_tmr3_t f,
    input logic split
  );
    tmr3_req = f.ovf | f.ext | (f.low & split);
  endfunction

  // Edge detection on one comparator output.
  function automatic logic comp_edge(
    input logic cur,
    input logic prev,
    input ira_edge_t sel
  );
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (sel)
      IRA_EDGE_RISE: comp_edge = rise;
      IRA_EDGE_FALL: comp_edge = fall;
      IRA_EDGE_BOTH: comp_edge = rise | fall;
      default: comp_edge = 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  ira_flags_t flags_r;
  ira_flags_t flags_nxt;
  ira_flags_t set_vec;
  ira_flags_t clr_vec;
  ira_flags_t upd_vec;
  logic [`IRA_NUM_COMP-1:0] comp_q_r;
  logic [`IRA_NUM_COMP-1:0] comp_hit;
  logic [`IRA_NUM_EXT-1:0] ext_vec_clr;
  logic [`IRA_NUM_EXT-1:0] ext_flag_nxt;
  logic [`IRA_NUM_EXT-1:0] ext_flag;
  logic [1:0] tmr01_vec_clr;
  logic [`IRA_NUM_SRC-1:0] src_raw;
  logic [`IRA_NUM_SRC-1:0] req_nxt;
  ira_prio_t [`IRA_NUM_SRC-1:0] prio_nxt;
  logic [`IRA_NUM_SRC-1:0] req_r;
  ira_prio_t [`IRA_NUM_SRC-1:0] prio_r;
  logic pend_r;
  logic vec_is_ext0;
  logic vec_is_ext1;
  logic vec_is_ext2;
  logic vec_is_ext3;
  logic vec_is_tmr0;
  logic vec_is_tmr1;
  logic sys_any;
  logic uart0_tx_routed;

  // --------------------------------------------------------------------------
  // Vector decode
  // --------------------------------------------------------------------------
  // Automatic clears happen in the cycle the vector is taken.
  assign vec_is_ext0 = VEC_TAKE & (VEC_ID == `IRA_SRC_EXT0);
  assign vec_is_ext1 = VEC_TAKE & (VEC_ID == `IRA_SRC_EXT1);
  assign vec_is_ext2 = VEC_TAKE & (VEC_ID == `IRA_SRC_EXT2);
  assign vec_is_ext3 = VEC_TAKE & (VEC_ID == `IRA_SRC_EXT3);
  assign vec_is_tmr0 = VEC_TAKE & (VEC_ID == `IRA_SRC_TMR0);
  assign vec_is_tmr1 = VEC_TAKE & (VEC_ID == `IRA_SRC_TMR1);

  assign ext_vec_clr = {vec_is_ext3, vec_is_ext2, vec_is_ext1, vec_is_ext0};
  assign tmr01_vec_clr = {vec_is_tmr1, vec_is_tmr0};

  // --------------------------------------------------------------------------
  // External interrupt flags
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `IRA_NUM_EXT; gi = gi + 1)
    begin : g_ext
      ira_ext_flag u_ext (
        .clk(CLK),
        .resetn(RESETN),
        .ce(CE),
        .pin(EXT_IRQ_PIN[gi]),
        .type_select(EXT_TYPE_SELECT[gi]),
        .polarity_invert(EXT_POLARITY_INVERT[gi]),
        .vec_clr(ext_vec_clr[gi]),
        .sw_set(SW_SET.ext[gi]),
        .sw_clr(SW_CLR.ext[gi]),
        .flag_nxt(ext_flag_nxt[gi]),
        .flag(ext_flag[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Comparator edge detection
  // --------------------------------------------------------------------------
  generate
    for (gi = 0; gi < `IRA_NUM_COMP; gi = gi + 1)
    begin : g_comp
      assign comp_hit[gi] = comp_edge(COMP_OUT[gi], comp_q_r[gi], COMP_EDGE_SEL[gi]);
    end
  endgenerate

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      comp_q_r <= '0;
    else if (CE)
      comp_q_r <= COMP_OUT;
  end

  // --------------------------------------------------------------------------
  // Flag set and clear vectors
  // --------------------------------------------------------------------------
  // Hardware events and software set pulses share one path, as do software
  // clears and automatic clears, so software acts exactly like hardware.
  always_comb
  begin
    set_vec = HW_SET | SW_SET;
    set_vec.comp = HW_SET.comp | SW_SET.comp | comp_hit;
    set_vec.ext = '0;
    clr_vec = SW_CLR;
    // Besides transition-mode external flags, only the timer 0 and timer 1 overflow flags are cleared on vectoring.
    clr_vec.tmr01 = SW_CLR.tmr01 | tmr01_vec_clr;
    clr_vec.ext = '0;
  end

  // Every other flag keeps its value through vectoring.
  assign upd_vec = flag_upd(flags_r, set_vec, clr_vec);

  always_comb
  begin
    flags_nxt = upd_vec;
    flags_nxt.ext = ext_flag_nxt;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      flags_r <= `IRA_FLAGS_RST;
    else if (CE)
      flags_r <= flags_nxt;
  end

  // --------------------------------------------------------------------------
  // Per-source request combination
  // --------------------------------------------------------------------------
  assign uart0_tx_routed = flags_nxt.uart[0].tx & UART0_TX_TO_SYSTEM_ROUTE_ENABLE;
  assign sys_any = (|flags_nxt.sys) | uart0_tx_routed;

  assign src_raw[`IRA_SRC_EXT0] = flags_nxt.ext[0];
  assign src_raw[`IRA_SRC_TMR0] = flags_nxt.tmr01[0];
  assign src_raw[`IRA_SRC_EXT1] = flags_nxt.ext[1];
  assign src_raw[`IRA_SRC_TMR1] = flags_nxt.tmr01[1];
  assign src_raw[`IRA_SRC_UART0] = flags_nxt.uart[0].rx | flags_nxt.uart[0].tx;
  assign src_raw[`IRA_SRC_TMR2] = tmr3_req(flags_nxt.tmr234[0], SPLIT_MODE[0]);
  assign src_raw[`IRA_SRC_EXT2] = flags_nxt.ext[2];
  assign src_raw[`IRA_SRC_SPI] = flags_nxt.spi;
  assign src_raw[`IRA_SRC_ADC] = |flags_nxt.adc;
  assign src_raw[`IRA_SRC_ARRAY] = flags_nxt.arr_ovf | (|flags_nxt.arr_evt);
  assign src_raw[`IRA_SRC_SYSTEM] = sys_any;
  assign src_raw[`IRA_SRC_KEYPAD] = flags_nxt.keypad;
  assign src_raw[`IRA_SRC_TWOWIRE0] = flags_nxt.twowire[0];
  assign src_raw[`IRA_SRC_COMP0] = flags_nxt.comp[0];
  assign src_raw[`IRA_SRC_UART1] = flags_nxt.uart[1].rx | flags_nxt.uart[1].tx;
  assign src_raw[`IRA_SRC_EXT3] = flags_nxt.ext[3];
  assign src_raw[`IRA_SRC_TMR3] = tmr3_req(flags_nxt.tmr234[1], SPLIT_MODE[1]);
  assign src_raw[`IRA_SRC_COMP1] = flags_nxt.comp[1];
  assign src_raw[`IRA_SRC_DMA] = |flags_nxt.dma;
  assign src_raw[`IRA_SRC_COMP2] = flags_nxt.comp[2];
  assign src_raw[`IRA_SRC_UART2] = flags_nxt.uart[2].rx | flags_nxt.uart[2].tx;
  assign src_raw[`IRA_SRC_TMR4] = tmr3_req(flags_nxt.tmr234[2], SPLIT_MODE[2]);
  assign src_raw[`IRA_SRC_UART3] = flags_nxt.uart[3].rx | flags_nxt.uart[3].tx;
  assign src_raw[`IRA_SRC_TWOWIRE1] = flags_nxt.twowire[1];

  // --------------------------------------------------------------------------
  // Enables and priority levels
  // --------------------------------------------------------------------------
  assign req_nxt = GLOBAL_IRQ_ENABLE ? (src_raw & SRC_ENABLE) : '0;

  generate
    for (gi = 0; gi < `IRA_NUM_SRC; gi = gi + 1)
    begin : g_prio
      assign prio_nxt[gi] = {PRIO_HIGH[gi], PRIO_LOW[gi]};
    end
  endgenerate

  // Requests are formed from the next flag state, so they line up with FLAGS.
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      req_r <= `IRA_REQ_RST;
      prio_r <= `IRA_PRIO_RST;
      pend_r <= 1'b0;
    end
    else if (CE)
    begin
      req_r <= req_nxt;
      prio_r <= prio_nxt;
      pend_r <= |req_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign FLAGS = flags_r;
  assign IRQ_REQ = req_r;
  assign IRQ_PRIO = prio_r;
  assign IRQ_PEND = pend_r;

endmodule

`default_nettype wire

// >>> verif/ira_props.sv
// Port checker of the interrupt request aggregator.
`timescale 1ns/100ps
`default_nettype none
`include "ira_cfg.svh"

module ira_props
  import ira_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // Inputs
  input wire logic [`IRA_NUM_EXT-1:0] EXT_IRQ_PIN,
  input wire logic [`IRA_NUM_EXT-1:0] EXT_TYPE_SELECT,
  input wire logic [`IRA_NUM_EXT-1:0] EXT_POLARITY_INVERT,
  input wire ira_flags_t HW_SET,
  input wire ira_flags_t SW_SET,
  input wire ira_flags_t SW_CLR,
  input wire logic UART0_TX_TO_SYSTEM_ROUTE_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic [`IRA_NUM_SRC-1:0] SRC_ENABLE,
  input wire logic [`IRA_NUM_SRC-1:0] PRIO_HIGH,
  input wire logic [`IRA_NUM_SRC-1:0] PRIO_LOW,
  input wire logic VEC_TAKE,
  input wire logic [`IRA_SRC_ID_W-1:0] VEC_ID,
  // Outputs
  input wire ira_flags_t FLAGS,
  input wire logic [`IRA_NUM_SRC-1:0] IRQ_REQ,
  input wire ira_prio_t [`IRA_NUM_SRC-1:0] IRQ_PRIO,
  input wire logic IRQ_PEND
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence ext0_fall_s;
    CE && EXT_IRQ_PIN[0] ##1 CE && !EXT_IRQ_PIN[0] && EXT_TYPE_SELECT[0] && !EXT_POLARITY_INVERT[0];
  endsequence

  sequence vec_s(logic [4:0] vid);
    CE && VEC_TAKE && VEC_ID == vid;
  endsequence

  ext_edge_a: assert property (ext0_fall_s |=> FLAGS.ext[0])
    else $error("edge mode flag not set");
  ext_level_a: assert property (CE && !EXT_TYPE_SELECT[0] && !EXT_POLARITY_INVERT[0] && !EXT_IRQ_PIN[0]
    |=> FLAGS.ext[0])
    else $error("level mode flag not following pin");
  ext_vclr_a: assert property (vec_s(5'h00) ##0 (EXT_TYPE_SELECT[0] && !EXT_POLARITY_INVERT[0]
    && EXT_IRQ_PIN[0] && !SW_SET.ext[0]) |=> !FLAGS.ext[0])
    else $error("edge flag kept after vector");
  tmr_clr_a: assert property (vec_s(5'h01) ##0 (!HW_SET.tmr01[0] && !SW_SET.tmr01[0])
    |=> !FLAGS.tmr01[0])
    else $error("timer flag kept after vector");
  spi_keep_a: assert property (vec_s(5'h07) ##0 (FLAGS.spi && !SW_CLR.spi) |=> FLAGS.spi)
    else $error("spi flag lost on vector");
  uart_keep_a: assert property (vec_s(5'h04) ##0 (FLAGS.uart[0].rx && !SW_CLR.uart[0].rx)
    |=> FLAGS.uart[0].rx)
    else $error("serial flag lost on vector");
  mask_all_a: assert property (CE && !GLOBAL_IRQ_ENABLE |=> IRQ_REQ == '0)
    else $error("request with global enable low");
  dma_req_a: assert property (CE |=> IRQ_REQ[18] == ($past(GLOBAL_IRQ_ENABLE) && $past(SRC_ENABLE[18])
    && FLAGS.dma != '0))
    else $error("dma request wrong");
  sys_req_a: assert property (CE |=> IRQ_REQ[10] == ($past(GLOBAL_IRQ_ENABLE) && $past(SRC_ENABLE[10])
    && (FLAGS.sys != '0 || FLAGS.uart[0].tx && $past(UART0_TX_TO_SYSTEM_ROUTE_ENABLE))))
    else $error("system request wrong");
  prio_copy_a: assert property (CE |=> IRQ_PRIO[5] == {$past(PRIO_HIGH[5]), $past(PRIO_LOW[5])})
    else $error("priority not copied");
  pend_or_a: assert property (IRQ_PEND == (IRQ_REQ != '0))
    else $error("pending not the or of requests");
endmodule

bind ira_top ira_props u_ira_props (
  .CLK, .RESETN, .CE, .EXT_IRQ_PIN, .EXT_TYPE_SELECT, .EXT_POLARITY_INVERT, .HW_SET, .SW_SET, .SW_CLR,
  .UART0_TX_TO_SYSTEM_ROUTE_ENABLE, .GLOBAL_IRQ_ENABLE, .SRC_ENABLE, .PRIO_HIGH, .PRIO_LOW,
  .VEC_TAKE, .VEC_ID, .FLAGS, .IRQ_REQ, .IRQ_PRIO, .IRQ_PEND
);
`default_nettype wire

// >>> verif/ira_core_model.sv
// Core-side vectoring model that takes the lowest numbered request.
`timescale 1ns/100ps
`default_nettype none
`include "ira_cfg.svh"

module ira_core_model
  import ira_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Request side
  input wire logic en,
  input wire logic [`IRA_NUM_SRC-1:0] req,
  input wire logic pend,
  // Vector side
  output logic take,
  output logic [`IRA_SRC_ID_W-1:0] id
);
  logic [`IRA_SRC_ID_W-1:0] first;

  always_comb
  begin
    first = '0;
    for (int j = `IRA_NUM_SRC - 1; j >= 0; j--)
      if (req[j])
        first = j[`IRA_SRC_ID_W-1:0];
  end

  // A vector is a one-cycle pulse and never follows another directly.
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      take <= 1'b0;
      id <= '0;
    end
    else
    begin
      take <= en && pend && !take;
      id <= first;
    end
endmodule
`default_nettype wire

// >>> verif/ira_top_bench.sv
// Self-checking testbench of the interrupt request aggregator.
`timescale 1ns/100ps
`default_nettype none
`include "ira_cfg.svh"

module ira_top_bench
  import ira_pkg::*;
;
  logic CLK, RESETN, CE, GLOBAL_IRQ_ENABLE, UART0_TX_TO_SYSTEM_ROUTE_ENABLE, VEC_TAKE, IRQ_PEND, en;
  logic [3:0] EXT_IRQ_PIN, EXT_TYPE_SELECT, EXT_POLARITY_INVERT;
  ira_flags_t HW_SET, SW_SET, SW_CLR, FLAGS;
  logic [2:0] SPLIT_MODE, COMP_OUT;
  ira_edge_t [2:0] COMP_EDGE_SEL;
  logic [23:0] SRC_ENABLE, PRIO_HIGH, PRIO_LOW, IRQ_REQ, exp;
  ira_prio_t [23:0] IRQ_PRIO;
  logic [4:0] VEC_ID;
  logic [54:0] f, b;
  int error_cnt = 0;
  int compares = 0;
  int map [55] = '{18, 18, 18, 13, 17, 19, 12, 23, 11, 10, 10, 10, 10, 10, 10, 10, 10, 10, 10, 9, 9, 9, 9, 9,
    9, 9, 9, 9, 8, 8, 8, 7, 5, 5, 5, 16, 16, 16, 21, 21, 21, 4, 4, 14, 14, 20, 20, 22, 22, 1, 3, 0, 2, 6, 15};

  ira_top u_ira_top (.CLK, .RESETN, .CE, .EXT_IRQ_PIN, .EXT_TYPE_SELECT, .EXT_POLARITY_INVERT, .HW_SET,
    .SW_SET, .SW_CLR, .SPLIT_MODE, .UART0_TX_TO_SYSTEM_ROUTE_ENABLE, .COMP_OUT, .COMP_EDGE_SEL,
    .GLOBAL_IRQ_ENABLE, .SRC_ENABLE, .PRIO_HIGH, .PRIO_LOW, .VEC_TAKE, .VEC_ID, .FLAGS, .IRQ_REQ,
    .IRQ_PRIO, .IRQ_PEND);
  ira_core_model u_ira_core_model (.clk(CLK), .resetn(RESETN), .en(en), .req(IRQ_REQ), .pend(IRQ_PEND),
    .take(VEC_TAKE), .id(VEC_ID));

  always #25 CLK = ~CLK;

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Applies one-cycle pulses, then lets one quiet edge pass.
  task drv(input logic [54:0] h, input logic [54:0] s, input logic [54:0] c);
    HW_SET = h;
    SW_SET = s;
    SW_CLR = c;
    @(negedge CLK);
    HW_SET = '0;
    SW_SET = '0;
    SW_CLR = '0;
    @(negedge CLK);
  endtask

  task vec;
    en = 1'b1;
    @(negedge CLK);
    en = 1'b0;
    repeat (2) @(negedge CLK);
  endtask

  task stop_test;
    $display("Checks %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #200us;
    error_cnt++;
    stop_test;
  end

  initial
  begin
    CLK = 1'b0;
    RESETN = 1'b0;
    CE = 1'b1;
    en = 1'b0;
    EXT_IRQ_PIN = 4'hF;
    EXT_TYPE_SELECT = 4'hF;
    EXT_POLARITY_INVERT = 4'h0;
    HW_SET = '0;
    SW_SET = '0;
    SW_CLR = '0;
    SPLIT_MODE = 3'h0;
    COMP_OUT = 3'h0;
    COMP_EDGE_SEL = {3{IRA_EDGE_NONE}};
    UART0_TX_TO_SYSTEM_ROUTE_ENABLE = 1'b0;
    GLOBAL_IRQ_ENABLE = 1'b1;
    SRC_ENABLE = 24'hFF_FFFF;
    PRIO_HIGH = 24'h00_0000;
    PRIO_LOW = 24'h00_0000;
    repeat (10) @(negedge CLK);
    RESETN = 1'b1;
    for (int i = 0; i < 55; i++)
    begin
      b = '0;
      b[i] = 1'b1;
      f = b;
      SPLIT_MODE = {3{i[0]}};
      UART0_TX_TO_SYSTEM_ROUTE_ENABLE = i[1];
      exp = (i == 34 || i == 40) ? 24'h00_0000 : 24'h00_0001 << map[i];
      exp[10] = exp[10] | (i == 42);
      if (i < 51 && !i[0])
        drv(b, '0, '0);
      else
        drv('0, b, '0);
      chk("flags", f, FLAGS);
      chk("request", exp, IRQ_REQ);
      chk("pending", |exp, IRQ_PEND);
      vec;
      if (i >= 49)
      begin
        f = '0;
        exp = '0;
      end
      chk("vectored flags", f, FLAGS);
      chk("vectored request", exp, IRQ_REQ);
      drv('0, '0, b);
      chk("cleared flags", 0, FLAGS);
    end
    b = '0;
    b[31] = 1'b1;
    drv(b, '0, '0);
    GLOBAL_IRQ_ENABLE = 1'b0;
    @(negedge CLK);
    chk("global mask", 0, IRQ_REQ);
    chk("global pending", 0, IRQ_PEND);
    GLOBAL_IRQ_ENABLE = 1'b1;
    SRC_ENABLE[7] = 1'b0;
    @(negedge CLK);
    chk("source mask", 0, IRQ_REQ);
    SRC_ENABLE[7] = 1'b1;
    CE = 1'b0;
    drv('0, '0, b);
    chk("frozen", 24'h00_0000, IRQ_REQ);
    CE = 1'b1;
    @(negedge CLK);
    chk("unmasked", 24'h00_0080, IRQ_REQ);
    drv('0, '0, b);
    PRIO_HIGH = 24'hAA_AAAA;
    PRIO_LOW = 24'hCC_CCCC;
    @(negedge CLK);
    for (int j = 0; j < 24; j++)
      chk("priority", {PRIO_HIGH[j], PRIO_LOW[j]}, IRQ_PRIO[j]);
    for (int k = 0; k < 4; k++)
    begin
      EXT_POLARITY_INVERT = {4{k[0]}};
      EXT_TYPE_SELECT = 4'h0;
      EXT_IRQ_PIN = {4{~k[0]}};
      @(negedge CLK);
      EXT_IRQ_PIN[k] = k[0];
      @(negedge CLK);
      chk("level flag", 1, FLAGS.ext[k]);
      vec;
      chk("level vectored", 1, FLAGS.ext[k]);
      EXT_IRQ_PIN[k] = ~k[0];
      @(negedge CLK);
      chk("level released", 0, FLAGS.ext[k]);
      EXT_TYPE_SELECT = 4'hF;
      EXT_IRQ_PIN[k] = k[0];
      @(negedge CLK);
      EXT_IRQ_PIN[k] = ~k[0];
      @(negedge CLK);
      chk("edge flag", 1, FLAGS.ext[k]);
      vec;
      chk("edge vectored", 0, FLAGS.ext[k]);
    end
    for (int s = 0; s < 4; s++)
    begin
      COMP_EDGE_SEL[0] = ira_edge_t'(s[1:0]);
      COMP_OUT[0] = 1'b1;
      @(negedge CLK);
      chk("rise", s == 1 || s == 3, FLAGS.comp[0]);
      drv('0, '0, '1);
      COMP_OUT[0] = 1'b0;
      @(negedge CLK);
      chk("fall", s >= 2, FLAGS.comp[0]);
      drv('0, '0, '1);
    end
    stop_test;
  end
endmodule
`default_nettype wire
